// file: inc/fpec_cfg.svh
// constants for the flash program/erase controller
// assumes a 16-bit word register port and a 50 MHz core clock
//
// Contract
// - main segments are 512 bytes, info segments 128; erase covers whole segment
// - only five op combinations: write, block write, erase, main mass, full mass
// - any other combination except all-clear on a flash write raises access violation
// - dummy write in erase mode erases segment, or main plus info area; with the mass bit alone the code erases the main area only
// - writing operation register while busy, except while awaiting the next block word, sets access violation
// - clock source field bits 7:6: 0 aux, 1 main, 2 and 3 sub-main
// - divider field bits 5:0 divides by value plus one, 1 to 64
// - timing generator resets on power-up clear and on emergency exit
// - clock config write while busy is dropped and sets access violation
// - busy bit 0 set at operation start, cleared at finish, not writable
// - busy stays high in block-write mode while awaiting next word
// - wrong password upper byte sets key violation bit 1 and a reset request
// - access violation bit 2 set by fetch during block write, never by reads
// - software may set access violation, which also raises the nmi
// - wait bit 3 high when block word done, low while programming
// - lock bit 4 lets current op finish, refuses new ones, flags writes
// - access violation setting also sets the lock bit
// - emergency exit bit 5 aborts, clears operation register, reads zero
// - cpu held on flash fetch while program or erase runs
// - all control bits cleared by power-up clear reset, except the clock config, which loads 42h
// - nmi sources share one vector, flags stay until software clears
`ifndef FPEC_CFG_SVH
`define FPEC_CFG_SVH

// ********************
// register offsets
// ********************
`define FPEC_OFS_OP        16'h0128
`define FPEC_OFS_CLK       16'h012a
`define FPEC_OFS_STAT      16'h012c
`define FPEC_PASSWORD      8'ha5
`define FPEC_PASSWORD_READ 8'h96

// ********************
// field positions
// ********************
`define FPEC_OP_ERASE      1
`define FPEC_OP_MASS       2
`define FPEC_OP_WRITE      6
`define FPEC_OP_BLOCK      7
`define FPEC_ST_BUSY       0
`define FPEC_ST_KEY_VIOL   1
`define FPEC_ST_ACCV       2
`define FPEC_ST_WAIT       3
`define FPEC_ST_LOCK       4
`define FPEC_ST_EXIT       5

// ********************
// reset values and timing
// ********************
`define FPEC_CLK_RESET     8'h42
`define FPEC_PROG_CYC      35
`define FPEC_ERASE_CYC     4819
`define FPEC_MASS_CYC      5297

`endif

// file: inc/fpec_pkg.sv
// types of the flash program/erase controller
// assumes nothing beyond the cfg header
package fpec_pkg;

  typedef enum logic [2:0] {
    FPEC_IDLE  = 3'b000,
    FPEC_PROG  = 3'b001,
    FPEC_BWAIT = 3'b011,
    FPEC_ERASE = 3'b010,
    FPEC_DONE  = 3'b110
  } fpec_state_e;

  typedef enum logic [2:0] {
    FPEC_OP_NONE,
    FPEC_OP_SINGLE,
    FPEC_OP_BLOCKW,
    FPEC_OP_SEG,
    FPEC_OP_MAIN,
    FPEC_OP_ALL,
    FPEC_OP_BAD
  } fpec_op_e;

endpackage : fpec_pkg

// file: src/fpec_clk_div.sv
// timing generator: clock select and divide-by-n tick
// assumes the three system clocks arrive as enables sync to core_clk
`timescale 1ns/1ps
`default_nettype none
module fpec_clk_div (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       gen_clear,
  // configuration
  input  wire logic [1:0] src_sel,
  input  wire logic [5:0] div_val,
  // clock enables
  input  wire logic       aux_clk_en,
  input  wire logic       main_clk_en,
  input  wire logic       sub_main_clk_en,
  // divided tick
  output logic            gen_tick
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } fpec_div_s;

  fpec_div_s div_reg;
  fpec_div_s div_next;
  logic      src_en;

  always_comb begin
    case (src_sel)
      2'h0:    src_en = aux_clk_en;
      2'h1:    src_en = main_clk_en;
      default: src_en = sub_main_clk_en;
    endcase
  end

  always_comb begin
    div_next      = div_reg;
    div_next.tick = 1'b0;
    if (gen_clear) begin
      div_next = '0;
    end else if (src_en) begin
      if (div_reg.cnt >= div_val) begin
        div_next.cnt  = 6'h00;
        div_next.tick = 1'b1;
      end else begin
        div_next.cnt = div_reg.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign gen_tick = div_reg.tick;

endmodule : fpec_clk_div
`default_nettype wire

// file: src/fpec_op_decode.sv
// decodes the operation-register bits into one of five operations, none, or bad
// assumes the op register low byte as input
`timescale 1ns/1ps
`default_nettype none
`include "fpec_cfg.svh"
module fpec_op_decode (
  // operation bits
  input  wire logic [7:0]        op_bits,
  // decoded operation
  output fpec_pkg::fpec_op_e     op_kind
);

  logic [3:0] combo;

  assign combo = {op_bits[`FPEC_OP_BLOCK], op_bits[`FPEC_OP_WRITE],
                  op_bits[`FPEC_OP_MASS], op_bits[`FPEC_OP_ERASE]};

  always_comb begin
    case (combo)
      4'h0:    op_kind = fpec_pkg::FPEC_OP_NONE;
      4'h4:    op_kind = fpec_pkg::FPEC_OP_SINGLE;
      4'hc:    op_kind = fpec_pkg::FPEC_OP_BLOCKW;
      4'h1:    op_kind = fpec_pkg::FPEC_OP_SEG;
      4'h2:    op_kind = fpec_pkg::FPEC_OP_MAIN;
      4'h3:    op_kind = fpec_pkg::FPEC_OP_ALL;
      default: op_kind = fpec_pkg::FPEC_OP_BAD;
    endcase
  end

endmodule : fpec_op_decode
`default_nettype wire

// file: src/fpec_ctrl.sv
// flash program/erase controller: registers, sequencer, array strobes
// assumes a single-cycle cpu register port and a flash array that
// acts on one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "fpec_cfg.svh"
module fpec_ctrl #(
  parameter int unsigned ADDR_W    = 16,
  parameter int unsigned MAIN_SEG  = 512,
  parameter int unsigned INFO_SEG  = 128,
  parameter logic [15:0] INFO_BASE = 16'h1000,
  parameter logic [15:0] INFO_END  = 16'h10ff,
  parameter int unsigned PROG_CYC  = `FPEC_PROG_CYC,
  parameter int unsigned ERASE_CYC = `FPEC_ERASE_CYC,
  parameter int unsigned MASS_CYC  = `FPEC_MASS_CYC
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [15:0]       reg_wdata,
  output logic      [15:0]       reg_rdata,
  // cpu flash access
  input  wire logic              fl_wr,
  input  wire logic [ADDR_W-1:0] fl_addr,
  input  wire logic [15:0]       fl_wdata,
  input  wire logic              fl_fetch,
  output logic                   cpu_hold,
  // clock enables
  input  wire logic              aux_clk_en,
  input  wire logic              main_clk_en,
  input  wire logic              sub_main_clk_en,
  // flash array
  output logic                   arr_prog,
  output logic                   arr_erase,
  output logic                   arr_erase_info,
  output logic      [ADDR_W-1:0] arr_addr,
  output logic      [15:0]       arr_data,
  output logic                   arr_active,
  // system
  input  wire logic              access_violation_irq_en,
  input  wire logic              access_violation_clr,
  output logic                   access_violation_nmi,
  output logic                   power_up_clear_req
);

  // ********************
  // state
  // ********************
  typedef struct packed {
    fpec_pkg::fpec_state_e st;
    logic [7:0]            op;
    logic [7:0]            clk_cfg;
    logic                  key_viol;
    logic                  accv;
    logic                  lock;
    logic [12:0]           steps;
    logic [ADDR_W-1:0]     addr;
    logic [15:0]           data;
    logic                  prog;
    logic                  erase;
    logic                  erase_info;
    logic                  pwr_clear;
    logic [15:0]           rdata;
  } fpec_ctrl_s;

  fpec_ctrl_s         s_reg;
  fpec_ctrl_s         s_next;
  fpec_pkg::fpec_op_e op_kind;
  logic               gen_tick;
  logic               gen_clear;
  logic               busy;
  logic               wait_flag;

  localparam logic [12:0] PROG_N  = 13'(PROG_CYC);
  localparam logic [12:0] ERASE_N = 13'(ERASE_CYC);
  localparam logic [12:0] MASS_N  = 13'(MASS_CYC);

  function automatic logic [ADDR_W-1:0] seg_base(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] sz;
    sz = (a >= ADDR_W'(INFO_BASE) && a <= ADDR_W'(INFO_END)) ?
         ADDR_W'(INFO_SEG) : ADDR_W'(MAIN_SEG);
    seg_base = a & ~(sz - ADDR_W'(1));
  endfunction : seg_base

  fpec_op_decode u_dec (
    .op_bits (s_reg.op),
    .op_kind (op_kind)
  );

  fpec_clk_div u_div (
    .core_clk        (core_clk),
    .srst            (srst),
    .gen_clear       (gen_clear),
    .src_sel         (s_reg.clk_cfg[7:6]),
    .div_val         (s_reg.clk_cfg[5:0]),
    .aux_clk_en      (aux_clk_en),
    .main_clk_en     (main_clk_en),
    .sub_main_clk_en (sub_main_clk_en),
    .gen_tick        (gen_tick)
  );

  // block mode keeps busy while waiting for the next word
  assign busy      = (s_reg.st != fpec_pkg::FPEC_IDLE);
  assign wait_flag = (s_reg.st == fpec_pkg::FPEC_BWAIT);
  assign gen_clear = reg_wr && reg_addr == `FPEC_OFS_STAT &&
                     reg_wdata[15:8] == `FPEC_PASSWORD &&
                     reg_wdata[`FPEC_ST_EXIT];

  // ********************
  // next state
  // ********************
  always_comb begin
    logic key_ok;
    logic hit;
    logic set_accv;
    key_ok   = reg_wdata[15:8] == `FPEC_PASSWORD;
    hit      = reg_wr && (reg_addr == `FPEC_OFS_OP ||
                          reg_addr == `FPEC_OFS_CLK ||
                          reg_addr == `FPEC_OFS_STAT);
    set_accv = 1'b0;
    s_next            = s_reg;
    s_next.prog       = 1'b0;
    s_next.erase      = 1'b0;
    s_next.erase_info = 1'b0;
    s_next.pwr_clear  = 1'b0;
    // clear first, so any set later in this cycle wins
    if (access_violation_clr) begin
      s_next.accv = 1'b0;
    end

    // register writes
    if (hit && !key_ok) begin
      s_next.key_viol  = 1'b1;
      s_next.pwr_clear = 1'b1;
    end else if (hit && reg_addr == `FPEC_OFS_OP) begin
      if (busy && !wait_flag) begin
        set_accv = 1'b1;
      end else begin
        s_next.op = reg_wdata[7:0];
      end
    end else if (hit && reg_addr == `FPEC_OFS_CLK) begin
      if (busy) begin
        set_accv = 1'b1;
      end else begin
        s_next.clk_cfg = reg_wdata[7:0];
      end
    end else if (hit) begin
      s_next.key_viol = reg_wdata[`FPEC_ST_KEY_VIOL];
      s_next.lock = reg_wdata[`FPEC_ST_LOCK];
      s_next.accv = reg_wdata[`FPEC_ST_ACCV];
    end

    // cpu fetch during an active block write
    if (fl_fetch && s_reg.op[`FPEC_OP_BLOCK] && busy) begin
      set_accv = 1'b1;
    end

    // writes into the array
    if (fl_wr) begin
      if (s_reg.lock || op_kind == fpec_pkg::FPEC_OP_BAD) begin
        set_accv = 1'b1;
      end else if (s_reg.st == fpec_pkg::FPEC_IDLE ||
                   s_reg.st == fpec_pkg::FPEC_BWAIT) begin
        s_next.data = fl_wdata;
        s_next.addr = fl_addr;
        case (op_kind)
          fpec_pkg::FPEC_OP_SINGLE,
          fpec_pkg::FPEC_OP_BLOCKW: begin
            s_next.st    = fpec_pkg::FPEC_PROG;
            s_next.steps = PROG_N;
          end
          fpec_pkg::FPEC_OP_SEG: begin
            s_next.addr  = seg_base(fl_addr);
            s_next.st    = fpec_pkg::FPEC_ERASE;
            s_next.steps = ERASE_N;
          end
          fpec_pkg::FPEC_OP_MAIN,
          fpec_pkg::FPEC_OP_ALL: begin
            s_next.st    = fpec_pkg::FPEC_ERASE;
            s_next.steps = MASS_N;
          end
          default: begin
            s_next.st = s_reg.st;
          end
        endcase
      end else begin
        set_accv = 1'b1;
      end
    end

    // sequencer
    case (s_reg.st)
      fpec_pkg::FPEC_PROG,
      fpec_pkg::FPEC_ERASE: begin
        if (gen_tick) begin
          if (s_reg.steps <= 13'h0001) begin
            s_next.st = fpec_pkg::FPEC_DONE;
          end else begin
            s_next.steps = s_reg.steps - 13'h0001;
          end
        end
      end
      fpec_pkg::FPEC_DONE: begin
        if (s_reg.op[`FPEC_OP_ERASE] || s_reg.op[`FPEC_OP_MASS]) begin
          s_next.erase      = 1'b1;
          s_next.erase_info = s_reg.op[`FPEC_OP_MASS] &&
                              s_reg.op[`FPEC_OP_ERASE];
        end else begin
          s_next.prog = 1'b1;
        end
        // lock ends block mode after the word in flight completes
        if (op_kind == fpec_pkg::FPEC_OP_BLOCKW && !s_reg.lock) begin
          s_next.st = fpec_pkg::FPEC_BWAIT;
        end else begin
          s_next.st = fpec_pkg::FPEC_IDLE;
          if (s_reg.lock) begin
            s_next.op[`FPEC_OP_BLOCK] = 1'b0;
          end
        end
      end
      fpec_pkg::FPEC_BWAIT: begin
        if (!s_reg.op[`FPEC_OP_BLOCK] || s_reg.lock) begin
          s_next.st = fpec_pkg::FPEC_IDLE;
        end
      end
      default: begin
        s_next.st = s_next.st;
      end
    endcase

    if (set_accv) begin
      s_next.accv = 1'b1;
    end
    if (set_accv || s_next.accv) begin
      s_next.lock = s_next.accv ? 1'b1 : s_next.lock;
    end

    // emergency exit wins over everything in flight
    if (gen_clear) begin
      s_next.st         = fpec_pkg::FPEC_IDLE;
      s_next.op         = 8'h00;
      s_next.steps      = 13'h0000;
      s_next.prog       = 1'b0;
      s_next.erase      = 1'b0;
      s_next.erase_info = 1'b0;
    end

    // read mux: reads never touch flags
    case (reg_addr)
      `FPEC_OFS_OP:   s_next.rdata = {`FPEC_PASSWORD_READ, s_reg.op};
      `FPEC_OFS_CLK:  s_next.rdata = {`FPEC_PASSWORD_READ, s_reg.clk_cfg};
      `FPEC_OFS_STAT: s_next.rdata = {`FPEC_PASSWORD_READ, 2'b00,
                                      1'b0, s_reg.lock, wait_flag,
                                      s_reg.accv, s_reg.key_viol,
                                      busy};
      default:        s_next.rdata = 16'h0000;
    endcase
    if (!reg_rd) begin
      s_next.rdata = s_reg.rdata;
    end
  end

  // ********************
  // registers
  // ********************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg         <= '0;
      s_reg.st      <= fpec_pkg::FPEC_IDLE;
      s_reg.clk_cfg <= `FPEC_CLK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ********************
  // outputs
  // ********************
  assign reg_rdata            = s_reg.rdata;
  assign cpu_hold             = busy && !wait_flag && fl_fetch;
  assign arr_prog             = s_reg.prog;
  assign arr_erase            = s_reg.erase;
  assign arr_erase_info       = s_reg.erase_info;
  assign arr_addr             = s_reg.addr;
  assign arr_data             = s_reg.data;
  assign arr_active           = busy && !wait_flag;
  assign access_violation_nmi = s_reg.accv &&
                                access_violation_irq_en;
  assign power_up_clear_req   = s_reg.pwr_clear;

endmodule : fpec_ctrl
`default_nettype wire

// file: dv/fpec_ctrl_props.sv
// port checker for the flash program/erase controller
// assumes it is bound onto fpec_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "fpec_cfg.svh"
module fpec_ctrl_props #(
  parameter int unsigned PROG_CYC = `FPEC_PROG_CYC
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // cpu and array
  input wire logic        fl_wr,
  input wire logic        fl_fetch,
  input wire logic        cpu_hold,
  input wire logic        arr_prog,
  input wire logic        arr_active,
  // system
  input wire logic        access_violation_irq_en,
  input wire logic        access_violation_clr,
  input wire logic        access_violation_nmi,
  input wire logic        power_up_clear_req
);
  // ********************
  // helpers
  // ********************
  logic [7:0] since_wr_reg;
  logic       key_bad;
  logic       rd_map;
  logic       stat_wr;
  assign key_bad = reg_wr && reg_wdata[15:8] != `FPEC_PASSWORD &&
    (reg_addr inside {`FPEC_OFS_OP, `FPEC_OFS_CLK, `FPEC_OFS_STAT});
  assign rd_map = reg_rd &&
    (reg_addr inside {`FPEC_OFS_OP, `FPEC_OFS_CLK, `FPEC_OFS_STAT});
  assign stat_wr = reg_wr && reg_addr == `FPEC_OFS_STAT;
  // saturating age of the last flash write, never wraps into a false pass
  always_ff @(posedge core_clk) begin
    if (srst || fl_wr) begin
      since_wr_reg <= 8'h00;
    end else if (since_wr_reg != 8'hff) begin
      since_wr_reg <= since_wr_reg + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ********************
  // assertions
  // ********************
  AST_KEY_RESET_REQ: assert property (key_bad |=> power_up_clear_req)
    else $error("bad key gave no reset request");
  AST_REQ_CAUSE: assert property (power_up_clear_req |-> $past(key_bad))
    else $error("reset request without bad key");
  AST_PROG_PULSE: assert property (arr_prog |=> !arr_prog)
    else $error("program strobe longer than one cycle");
  AST_PROG_MIN: assert property (arr_prog |-> since_wr_reg >= PROG_CYC)
    else $error("program ended too early");
  AST_HOLD: assert property (cpu_hold |-> fl_fetch && arr_active)
    else $error("cpu held without fetch during operation");
  AST_NMI_EN: assert property (access_violation_nmi |-> access_violation_irq_en)
    else $error("nmi while disabled");
  AST_NMI_STAYS: assert property (access_violation_nmi &&
    !access_violation_clr && !stat_wr ##1 access_violation_irq_en
    |-> access_violation_nmi)
    else $error("violation flag dropped by itself");
  AST_RD_KEY: assert property (rd_map |=> reg_rdata[15:8] == `FPEC_PASSWORD_READ)
    else $error("read upper byte wrong");
  AST_EXIT_RD: assert property (reg_rd && reg_addr == `FPEC_OFS_STAT
    |=> !reg_rdata[`FPEC_ST_EXIT])
    else $error("exit bit read as one");
endmodule : fpec_ctrl_props
bind fpec_ctrl fpec_ctrl_props #(.PROG_CYC(PROG_CYC)) fpec_ctrl_props_i (
  .core_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .fl_wr, .fl_fetch, .cpu_hold, .arr_prog, .arr_active,
  .access_violation_irq_en, .access_violation_clr, .access_violation_nmi,
  .power_up_clear_req);
`default_nettype wire

// file: dv/fpec_flash_model.sv
// flash array model: counts strobes, keeps last address and data
// assumes one-cycle strobes from the controller
`timescale 1ns/1ps
`default_nettype none
module fpec_flash_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // array strobes
  input  wire logic        arr_prog,
  input  wire logic        arr_erase,
  input  wire logic        arr_erase_info,
  input  wire logic [15:0] arr_addr,
  input  wire logic [15:0] arr_data,
  // observed activity
  output logic      [7:0]  prog_cnt,
  output logic      [7:0]  erase_cnt,
  output logic      [7:0]  info_cnt,
  output logic      [15:0] last_addr,
  output logic      [15:0] last_data
);
  // ********************
  // strobe capture
  // ********************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prog_cnt <= 8'h00;
      erase_cnt <= 8'h00;
      info_cnt <= 8'h00;
    end else begin
      if (arr_prog) begin
        prog_cnt <= prog_cnt + 8'h01;
        last_addr <= arr_addr;
        last_data <= arr_data;
      end
      if (arr_erase) begin
        erase_cnt <= erase_cnt + 8'h01;
        last_addr <= arr_addr;
      end
      if (arr_erase_info) info_cnt <= info_cnt + 8'h01;
    end
  end
endmodule : fpec_flash_model
`default_nettype wire

// file: dv/test_flash_program_erase_controller.sv
// self-checking bench for the flash program/erase controller
// assumes the checker binds itself and the array model sits beside
`timescale 1ns/1ps
`default_nettype none
`include "fpec_cfg.svh"
module test_flash_program_erase_controller;
  // ********************
  // signals
  // ********************
  localparam logic [15:0] OP = `FPEC_OFS_OP;
  localparam logic [15:0] CK = `FPEC_OFS_CLK;
  localparam logic [15:0] ST = `FPEC_OFS_STAT;
  localparam logic [15:0] K = 16'ha500;
  localparam logic [15:0] RK = 16'h9600;
  localparam int PC = 3;
  localparam logic [5:0] DV [4] = '{6'h01, 6'h05, 6'h02, 6'h3f};
  localparam int PER [4] = '{4, 1, 2, 2};
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic fl_wr = 1'b0, fl_fetch = 1'b0, access_violation_clr = 1'b0;
  logic access_violation_irq_en = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
  logic [15:0] fl_addr = 16'h0000, fl_wdata = 16'h0000;
  logic [15:0] reg_rdata, arr_addr, arr_data, last_addr, last_data;
  logic cpu_hold, arr_prog, arr_erase, arr_erase_info, arr_active;
  logic access_violation_nmi, power_up_clear_req;
  logic [7:0] prog_cnt, erase_cnt, info_cnt;
  logic [1:0] en_cnt = 2'h0;
  int errors = 0, check_count = 0;
  wire aux_clk_en = (en_cnt == 2'h0);
  wire main_clk_en = 1'b1;
  wire sub_main_clk_en = en_cnt[0];
  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) en_cnt <= en_cnt + 2'h1;
  fpec_ctrl #(.PROG_CYC(PC), .ERASE_CYC(4), .MASS_CYC(5)) fpec_ctrl_i (
    .core_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .fl_wr, .fl_addr, .fl_wdata, .fl_fetch, .cpu_hold, .aux_clk_en,
    .main_clk_en, .sub_main_clk_en, .arr_prog, .arr_erase, .arr_erase_info,
    .arr_addr, .arr_data, .arr_active, .access_violation_irq_en,
    .access_violation_clr, .access_violation_nmi, .power_up_clear_req);
  fpec_flash_model fpec_flash_model_i (.core_clk, .srst, .arr_prog,
    .arr_erase, .arr_erase_info, .arr_addr, .arr_data, .prog_cnt,
    .erase_cnt, .info_cnt, .last_addr, .last_data);
  // ********************
  // bus tasks
  // ********************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge core_clk);
    reg_rd = 1'b1; reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0; d = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] s;
    rd(a, s);
    chk(s, e);
  endtask : rdc
  task automatic fw(input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    fl_wr = 1'b1; fl_addr = a; fl_wdata = d;
    @(negedge core_clk);
    fl_wr = 1'b0;
  endtask : fw
  // status polling is bounded; a stuck flag shows up as a mismatch
  task automatic poll(input logic [15:0] m, input logic [15:0] v);
    logic [15:0] s;
    for (int i = 0; i < 1500; i++) begin
      rd(ST, s);
      if ((s & m) === v) break;
    end
    chk(s & m, v);
  endtask : poll
  // ********************
  // scenarios
  // ********************
  task automatic t_timing;
    int n;
    int t;
    for (int i = 0; i < 4; i++) begin
      wr(CK, K | {8'h00, 2'(i), DV[i]});
      rdc(CK, RK | {8'h00, 2'(i), DV[i]});
      wr(OP, K | 16'h0040);
      fw(16'hf010 + 16'(2 * i), 16'h1234 + 16'(i));
      n = 0;
      while (arr_prog !== 1'b1 && n < 2000) begin
        @(negedge core_clk);
        n++;
      end
      t = PC * (int'(DV[i]) + 1) * PER[i];
      chk(16'(n >= t - t / PC + 2 && n <= t + 1), 16'h1);
      @(negedge core_clk);
      chk(last_data, 16'h1234 + 16'(i));
      poll(16'h0001, 16'h0000);
    end
    wr(CK, K | 16'h0042);
  endtask : t_timing
  task automatic t_ops;
    logic [7:0] e0;
    logic [7:0] f0;
    logic [7:0] p0;
    logic [7:0] bad [4] = '{8'h42, 8'hc2, 8'h80, 8'h44};
    p0 = prog_cnt;
    e0 = erase_cnt;
    for (int i = 0; i < 4; i++) begin
      wr(OP, K | {8'h00, bad[i]});
      fw(16'hf000, 16'h0000);
      rdc(ST, RK | 16'h0014);
      wr(ST, K);
    end
    wr(ST, K | 16'h0010);
    wr(OP, K | 16'h0040);
    fw(16'hf000, 16'h0000);
    rdc(ST, RK | 16'h0014);
    chk(16'(prog_cnt - p0) | 16'(erase_cnt - e0), 16'h0);
    wr(ST, K);
    for (int i = 0; i < 3; i++) begin
      e0 = erase_cnt;
      f0 = info_cnt;
      wr(OP, K | {13'h0000, 2'(i + 1), 1'b0});
      fw(16'h1094, 16'h0000);
      poll(16'h0001, 16'h0000);
      chk(16'(info_cnt - f0), 16'(i == 2));
      if (i < 2) chk(16'(erase_cnt - e0), 16'h0001);
      if (i == 0) chk(last_addr, 16'h1080);
    end
  endtask : t_ops
  task automatic t_block;
    logic [7:0] p0;
    p0 = prog_cnt;
    wr(OP, K | 16'h00c0);
    fw(16'hf100, 16'haaaa);
    poll(16'h0009, 16'h0009);
    fw(16'hf102, 16'h5555);
    rdc(ST, RK | 16'h0001);
    poll(16'h0009, 16'h0009);
    chk(16'(prog_cnt - p0), 16'h0002);
    @(negedge core_clk);
    fl_fetch = 1'b1;
    @(negedge core_clk);
    fl_fetch = 1'b0;
    poll(16'h0004, 16'h0004);
    wr(OP, K);
    wr(ST, K);
    poll(16'h0001, 16'h0000);
  endtask : t_block
  task automatic t_busy;
    logic [7:0] e0;
    e0 = erase_cnt;
    wr(CK, K | 16'h003f);
    wr(OP, K | 16'h0002);
    fw(16'hf234, 16'h0000);
    rdc(ST, RK | 16'h0001);
    @(negedge core_clk);
    fl_fetch = 1'b1;
    @(negedge core_clk);
    chk(16'(cpu_hold), 16'h0001);
    chk(16'(arr_active), 16'h0001);
    fl_fetch = 1'b0;
    wr(CK, K | 16'h0042);
    rdc(CK, RK | 16'h003f);
    rdc(ST, RK | 16'h0015);
    wr(ST, K);
    wr(OP, K | 16'h0040);
    rdc(ST, RK | 16'h0015);
    poll(16'h0001, 16'h0000);
    chk(16'(erase_cnt - e0), 16'h0001);
    chk(last_addr, 16'hf200);
    access_violation_irq_en = 1'b1;
    @(negedge core_clk);
    chk(16'(access_violation_nmi), 16'h0001);
    access_violation_clr = 1'b1;
    @(negedge core_clk);
    access_violation_clr = 1'b0;
    access_violation_irq_en = 1'b0;
    @(negedge core_clk);
    access_violation_irq_en = 1'b1;
    @(negedge core_clk);
    chk(16'(access_violation_nmi), 16'h0000);
    access_violation_irq_en = 1'b0;
    wr(ST, K);
    wr(CK, K | 16'h0042);
  endtask : t_busy
  task automatic t_exit;
    logic [7:0] e0;
    logic [7:0] p0;
    wr(CK, K | 16'h003f);
    e0 = erase_cnt;
    wr(OP, K | 16'h0002);
    fw(16'hf400, 16'h0000);
    wr(ST, K | 16'h0020);
    rdc(ST, RK);
    rdc(OP, RK);
    repeat (1100) @(negedge core_clk);
    chk(16'(erase_cnt - e0), 16'h0000);
    wr(CK, K | 16'h0042);
    p0 = prog_cnt;
    wr(OP, K | 16'h0040);
    fw(16'hf020, 16'h00ff);
    poll(16'h0001, 16'h0000);
    chk(16'(prog_cnt - p0), 16'h0001);
  endtask : t_exit
  task automatic t_key;
    wr(CK, 16'h5a10);
    chk(16'(power_up_clear_req), 16'h0001);
    rdc(ST, RK | 16'h0002);
    rdc(CK, RK | 16'h0042);
    @(negedge core_clk);
    srst = 1'b1;
    @(negedge core_clk);
    srst = 1'b0;
    rdc(ST, RK);
    rdc(OP, RK);
    wr(ST, K | 16'h0004);
    rdc(ST, RK | 16'h0014);
    access_violation_irq_en = 1'b1;
    repeat (20) @(negedge core_clk);
    chk(16'(access_violation_nmi), 16'h0001);
  endtask : t_key
  // ********************
  // run control
  // ********************
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    rdc(OP, RK);
    rdc(CK, RK | 16'h0042);
    rdc(ST, RK);
    t_timing();
    t_ops();
    t_block();
    t_busy();
    t_exit();
    t_key();
    print_verdict();
  end
endmodule : test_flash_program_erase_controller
`default_nettype wire
